//--- verilog/usp_defs.svh
// Overview of operation
// [RULE1] overflow set also sets sticky summary bit
// [RULE2] compares and non-overflowing ops keep summary bit
// [RULE3] overflow flag equals carry0 xor carry1
// [RULE4] carrying ops set carry flag from carry0
// [RULE5] arithmetic right shift: carry if ones lost; the code sets carry only when the operand is negative
// [RULE6] flags come from the full three-operand sum
// [RULE7] exception bits 16..23 store and return writes
// [RULE8] other reserved exception bits read zero
// [RULE9] bits 25..31 hold string byte count
// [RULE10] link register gives branch-to-link target
// [RULE11] link low bits stored, masked as address
// [RULE12] linking branch writes next address, taken or not
// [RULE13] branch option may decrement loop count
// [RULE14] decrementing zero count wraps to all ones
// [RULE15] loop count gives branch-to-count target
// [RULE16] 64-bit unsigned time count increments periodically
// [RULE17] time count split into upper, lower halves
// [RULE18] time count written only at supervisor level
// [RULE19] time count read and write numbers differ
// [RULE20] each read returns one 32-bit half
// [RULE21] reset leaves exception, link, count untouched
// [RULE22] tick pulse advances count, carry same cycle
`ifndef USP_DEFS_SVH
`define USP_DEFS_SVH

// special-purpose register numbers
`define USP_SPR_FLAGS      10'h001
`define USP_SPR_LINK       10'h008
`define USP_SPR_COUNT      10'h009
`define USP_SPR_TIME_LO_RD 10'h10c
`define USP_SPR_TIME_HI_RD 10'h10d
`define USP_SPR_TIME_LO_WR 10'h11c
`define USP_SPR_TIME_HI_WR 10'h11d

// exception register field positions (little-endian bit index)
`define USP_FLD_SUMMARY    31
`define USP_FLD_SIGNED     30
`define USP_FLD_UNSIGNED   29
`define USP_FLD_KEEP_HI    15
`define USP_FLD_KEEP_LO    8
`define USP_FLD_BYTES_HI   6

// reset values of the registers that do reset
`define USP_RST_TIME       64'h0000_0000_0000_0000
`define USP_RST_RDATA      32'h0000_0000

`endif

//--- verilog/usp_pkg.sv
package usp_pkg;

   // decoded special-purpose register selection
   typedef enum logic [2:0] {
      USP_SEL_NONE,
      USP_SEL_FLAGS,
      USP_SEL_LINK,
      USP_SEL_COUNT,
      USP_SEL_TIME_LO_RD,
      USP_SEL_TIME_HI_RD,
      USP_SEL_TIME_LO_WR,
      USP_SEL_TIME_HI_WR
   } usp_sel_t;

endpackage

//--- verilog/usp_time_if.sv
`timescale 1ns/1ns
`default_nettype none
// carrier between the register file and the time counter
interface usp_time_if;
   logic        tick;      // advance pulse
   logic        wr_upper;  // load upper half
   logic        wr_lower;  // load lower half
   logic [31:0] wdata;     // load value
   logic [31:0] upper;     // upper half value
   logic [31:0] lower;     // lower half value

   modport ctl (output tick, output wr_upper, output wr_lower,
                output wdata, input upper, input lower);
   modport cnt (input tick, input wr_upper, input wr_lower,
                input wdata, output upper, output lower);
endinterface
`default_nettype wire

//--- verilog/usp_time_count.sv
`timescale 1ns/1ns
`default_nettype none
`include "usp_defs.svh"
// 64-bit time count, advanced only on the tick pulse and presented as two halves
module usp_time_count
   import usp_pkg::*;
(
   input wire logic clk,    // core clock
   input wire logic rst_n,  // async reset, active low
   usp_time_if.cnt  tc      // control and value bundle
);

   logic [63:0] count;      // full time count
   logic [63:0] next_count; // value for the next edge

   ////////////////////////////////////////////////////////////////////
   // next value: increment, then supervisor loads override a half
   always_comb begin
      next_count = count;
      if (tc.tick) begin
         next_count = count + 64'h1;          // RULE16 RULE22
      end
      if (tc.wr_upper) begin
         next_count[63:32] = tc.wdata;        // RULE17
      end
      if (tc.wr_lower) begin
         next_count[31:0] = tc.wdata;         // RULE17
      end
   end

   // count register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count <= `USP_RST_TIME;
      end else begin
         count <= next_count;
      end
   end

   assign tc.upper = count[63:32];            // RULE17
   assign tc.lower = count[31:0];

   ////////////////////////////////////////////////////////////////////
   // checks
   AST_TIME_CARRY: assert property (@(posedge clk) // RULE22
      disable iff (!rst_n)
      (tc.tick && !tc.wr_upper && !tc.wr_lower
       && count[31:0] == 32'hffffffff)
      |=> (count[31:0] == 32'h0
           && count[63:32] == $past(count[63:32]) + 32'h1))
      else $error("time count carry into upper half lost");

   AST_TIME_HOLD: assert property (@(posedge clk) // RULE16
      disable iff (!rst_n)
      (!tc.tick && !tc.wr_upper && !tc.wr_lower) |=> $stable(count))
      else $error("time count moved without a tick");

endmodule
`default_nettype wire

//--- verilog/usp_sprs.sv
`timescale 1ns/1ns
`default_nettype none
`include "usp_defs.svh"
// user-level integer special-purpose registers
module usp_sprs
   import usp_pkg::*;
(
   input  wire logic        clk,            // core clock
   input  wire logic        rst_n,          // async reset, active low
   // register move port
   input  wire logic        spr_wr_en,      // move-to strobe
   input  wire logic        spr_rd_en,      // move-from strobe
   input  wire logic [9:0]  spr_num,        // register number
   input  wire logic [31:0] spr_wdata,      // move-to data
   input  wire logic        spr_supervisor, // supervisor privilege
   output logic [31:0]      spr_rdata,      // move-from data, next cycle
   // integer unit: add and subtract
   input  wire logic        arith_valid,    // add/subtract completes
   input  wire logic        arith_ovf_en,   // overflow-record enable
   input  wire logic        arith_carrying, // carrying or extended form
   input  wire logic [31:0] arith_a,        // first addend
   input  wire logic [31:0] arith_b,        // second addend
   input  wire logic        arith_cin,      // third addend, one bit
   // integer unit: shift right algebraic
   input  wire logic        sra_valid,      // shift completes
   input  wire logic [31:0] sra_src,        // shifted operand
   input  wire logic [5:0]  sra_amt,        // shift amount 0..63
   // branch unit
   input  wire logic        br_valid,       // branch completes
   input  wire logic        br_link,        // link requested
   input  wire logic        br_dec_count,   // branch_option_field asks
   input  wire logic [31:0] br_next_addr,   // address after branch
   // time base rate
   input  wire logic        time_tick,      // one-cycle rate pulse
   // values for the rest of the core
   output logic [31:0]      link_target,    // branch_cond_to_link target
   output logic [31:0]      count_target,   // branch_cond_to_count target
   output logic [31:0]      loop_count_val, // loop_count contents
   output logic             summary_ovf,    // sticky summary bit
   output logic             carry_flag,     // unsigned_wrap_flag
   output logic [6:0]       string_bytes    // load_string_indexed length
);

   ////////////////////////////////////////////////////////////////////
   // storage
   logic        sum_ovf;            // sticky summary overflow
   logic        signed_wrap_flag;   // overflow
   logic        unsigned_wrap_flag; // carry
   logic [7:0]  keep_bits;          // reserved bits that store
   logic [6:0]  byte_count;         // string transfer length
   logic [31:0] branch_return_link; // link register
   logic [31:0] loop_count;         // count register

   usp_time_if  tbus ();            // time counter bundle

   ////////////////////////////////////////////////////////////////////
   // helpers

   // decode a register number with the access direction
   function automatic usp_sel_t decode_spr(input logic [9:0] num,
                                           input logic       wr);
      usp_sel_t sel;
      sel = USP_SEL_NONE;
      case (num)
         `USP_SPR_FLAGS:      sel = USP_SEL_FLAGS;
         `USP_SPR_LINK:       sel = USP_SEL_LINK;
         `USP_SPR_COUNT:      sel = USP_SEL_COUNT;
         `USP_SPR_TIME_LO_RD: sel = wr ? USP_SEL_NONE : USP_SEL_TIME_LO_RD;
         `USP_SPR_TIME_HI_RD: sel = wr ? USP_SEL_NONE : USP_SEL_TIME_HI_RD;
         `USP_SPR_TIME_LO_WR: sel = wr ? USP_SEL_TIME_LO_WR : USP_SEL_NONE;
         `USP_SPR_TIME_HI_WR: sel = wr ? USP_SEL_TIME_HI_WR : USP_SEL_NONE;
         default:             sel = USP_SEL_NONE;
      endcase
      return sel;
   endfunction

   // address form of a register: low two bits ignored
   function automatic logic [31:0] as_addr(input logic [31:0] v);
      return {v[31:2], 2'b00};
   endfunction

   ////////////////////////////////////////////////////////////////////
   // decode of the move port
   usp_sel_t wsel;  // write target
   usp_sel_t rsel;  // read source
   logic     wr_flags, wr_link, wr_count; // register write strobes

   assign wsel     = spr_wr_en ? decode_spr(spr_num, 1'b1) : USP_SEL_NONE;
   assign rsel     = decode_spr(spr_num, 1'b0);
   assign wr_flags = (wsel == USP_SEL_FLAGS);
   assign wr_link  = (wsel == USP_SEL_LINK);
   assign wr_count = (wsel == USP_SEL_COUNT);

   ////////////////////////////////////////////////////////////////////
   // add/subtract flags from the whole three-operand sum
   logic [32:0] full_sum;  // sum with carry out of the top bit
   logic [31:0] low_sum;   // sum of the lower 31 bits, carry at [31]
   logic        carry_top; // carry out of the most significant bit
   logic        carry_sub; // carry into the most significant bit
   logic        ovf_calc;  // signed overflow of the instruction

   assign full_sum  = {1'b0, arith_a} + {1'b0, arith_b}
                    + {32'h0, arith_cin};                   // RULE6
   assign low_sum   = {1'b0, arith_a[30:0]} + {1'b0, arith_b[30:0]}
                    + {31'h0, arith_cin};                   // RULE6
   assign carry_top = full_sum[32];
   assign carry_sub = low_sum[31];
   assign ovf_calc  = carry_top ^ carry_sub;                // RULE3

   ////////////////////////////////////////////////////////////////////
   // shift right algebraic: ones lost from a negative operand
   logic [31:0] lost_mask; // bit positions shifted out
   logic        sra_carry; // carry result of the shift

   always_comb begin
      if (sra_amt[5]) begin
         lost_mask = 32'hffffffff;      // everything leaves
      end else begin
         lost_mask = (32'h1 << sra_amt[4:0]) - 32'h1;
      end
   end
   assign sra_carry = sra_src[31] & (|(sra_src & lost_mask)); // RULE5

   ////////////////////////////////////////////////////////////////////
   // exception register: no reset, contents survive it
   always_ff @(posedge clk) begin                           // RULE21
      // software move comes first, unit results override it
      if (wr_flags) begin
         sum_ovf            <= spr_wdata[`USP_FLD_SUMMARY];
         signed_wrap_flag   <= spr_wdata[`USP_FLD_SIGNED];
         unsigned_wrap_flag <= spr_wdata[`USP_FLD_UNSIGNED];
         keep_bits          <=
            spr_wdata[`USP_FLD_KEEP_HI:`USP_FLD_KEEP_LO];   // RULE7
         byte_count         <= spr_wdata[`USP_FLD_BYTES_HI:0]; // RULE9
      end
      // overflow recorded only by enabled add/subtract
      if (arith_valid && arith_ovf_en) begin
         signed_wrap_flag <= ovf_calc;                      // RULE3
         if (ovf_calc) begin                                // RULE2
            sum_ovf <= 1'b1;                                // RULE1
         end
      end
      // carry from carrying or extended forms
      if (arith_valid && arith_carrying) begin
         unsigned_wrap_flag <= carry_top;                   // RULE4
      end
      // carry from algebraic shift
      if (sra_valid) begin
         unsigned_wrap_flag <= sra_carry;                   // RULE5
      end
   end

   // full read image; unlisted reserved bits are zero
   logic [31:0] flags_word; // exception register as read
   assign flags_word = {sum_ovf, signed_wrap_flag, unsigned_wrap_flag,
                        13'h0000, keep_bits, 1'b0, byte_count}; // RULE8

   ////////////////////////////////////////////////////////////////////
   // link register: branch write wins over a software move
   always_ff @(posedge clk) begin                           // RULE21
      if (br_valid && br_link) begin
         branch_return_link <= br_next_addr;                // RULE12
      end else if (wr_link) begin
         branch_return_link <= spr_wdata;                   // RULE11
      end
   end

   ////////////////////////////////////////////////////////////////////
   // count register: decrement wins over a software move
   always_ff @(posedge clk) begin                           // RULE21
      if (br_valid && br_dec_count) begin
         loop_count <= loop_count - 32'h1;                  // RULE13 RULE14
      end else if (wr_count) begin
         loop_count <= spr_wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // time counter, written only by supervisor code
   assign tbus.tick     = time_tick;                        // RULE22
   assign tbus.wdata    = spr_wdata;
   assign tbus.wr_upper = spr_supervisor
                        && (wsel == USP_SEL_TIME_HI_WR);    // RULE18 RULE19
   assign tbus.wr_lower = spr_supervisor
                        && (wsel == USP_SEL_TIME_LO_WR);    // RULE18 RULE19

   usp_time_count usp_time_count_i (
      .clk   (clk),
      .rst_n (rst_n),
      .tc    (tbus.cnt)
   );

   ////////////////////////////////////////////////////////////////////
   // read port: one half of the time count per read
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         spr_rdata <= `USP_RST_RDATA;
      end else if (spr_rd_en) begin
         case (rsel)
            USP_SEL_FLAGS:      spr_rdata <= flags_word;
            USP_SEL_LINK:       spr_rdata <= branch_return_link;
            USP_SEL_COUNT:      spr_rdata <= loop_count;
            USP_SEL_TIME_LO_RD: spr_rdata <= tbus.lower;    // RULE20
            USP_SEL_TIME_HI_RD: spr_rdata <= tbus.upper;    // RULE20
            default:            spr_rdata <= `USP_RST_RDATA; // unmapped
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // values to the branch and integer units
   assign link_target    = as_addr(branch_return_link);     // RULE10 RULE11
   assign count_target   = as_addr(loop_count);             // RULE15
   assign loop_count_val = loop_count;
   assign summary_ovf    = sum_ovf;
   assign carry_flag     = unsigned_wrap_flag;
   assign string_bytes   = byte_count;                      // RULE9

   ////////////////////////////////////////////////////////////////////
   // checks
   sequence s_ovf_add;
      arith_valid && arith_ovf_en && ovf_calc;
   endsequence

   sequence s_no_ovf_source;
      !(arith_valid && arith_ovf_en) && !wr_flags;
   endsequence

   AST_SUMMARY_SET: assert property (@(posedge clk) disable iff (!rst_n)
      s_ovf_add |=> (sum_ovf && signed_wrap_flag)) // RULE1
      else $error("overflow did not set the summary bit");

   AST_SUMMARY_KEEP: assert property (@(posedge clk) disable iff (!rst_n)
      s_no_ovf_source |=> $stable(sum_ovf)) // RULE2
      else $error("summary bit changed without overflow source");

   AST_SIGNED_KEEP: assert property (@(posedge clk) // RULE2
      disable iff (!rst_n) s_no_ovf_source |=> $stable(signed_wrap_flag))
      else $error("signed wrap flag changed without a source");

   AST_SIGNED_CALC: assert property (@(posedge clk) // RULE3
      disable iff (!rst_n) (arith_valid && arith_ovf_en)
      |=> signed_wrap_flag == $past(ovf_calc))
      else $error("signed wrap flag wrong");

   AST_CARRY_KEEP: assert property (@(posedge clk) // RULE4
      disable iff (!rst_n)
      (!(arith_valid && arith_carrying) && !sra_valid && !wr_flags)
      |=> $stable(unsigned_wrap_flag))
      else $error("carry flag changed without a source");

   AST_FLAGS_STORE: assert property (@(posedge clk) // RULE7
      disable iff (!rst_n) wr_flags
      |=> keep_bits == $past(spr_wdata[`USP_FLD_KEEP_HI:`USP_FLD_KEEP_LO])
       && byte_count == $past(spr_wdata[`USP_FLD_BYTES_HI:0]))
      else $error("stored exception bits wrong");

   AST_CARRY_ADD: assert property (@(posedge clk) disable iff (!rst_n)
      (arith_valid && arith_carrying && !sra_valid)
      |=> unsigned_wrap_flag == $past(full_sum[32])) // RULE4
      else $error("carry flag wrong after carrying add");

   AST_CARRY_SHIFT: assert property (@(posedge clk) disable iff (!rst_n)
      sra_valid |=> unsigned_wrap_flag == $past(sra_carry)) // RULE5
      else $error("carry flag wrong after algebraic shift");

   AST_RESERVED_READ: assert property (@(posedge clk) disable iff (!rst_n)
      (spr_rd_en && rsel == USP_SEL_FLAGS)
      |=> (spr_rdata[28:16] == 13'h0 && spr_rdata[7] == 1'b0)) // RULE8
      else $error("reserved exception bits not zero");

   AST_LINK_WRITE: assert property (@(posedge clk) // RULE12
      disable iff (!rst_n) (br_valid && br_link)
      |=> branch_return_link == $past(br_next_addr))
      else $error("link register not loaded by branch");

   AST_LINK_MOVE: assert property (@(posedge clk) // RULE11
      disable iff (!rst_n) (wr_link && !(br_valid && br_link))
      |=> branch_return_link == $past(spr_wdata))
      else $error("link register lost a software write");

   AST_COUNT_WRAP: assert property (@(posedge clk) // RULE14
      disable iff (!rst_n) (br_valid && br_dec_count && loop_count == 32'h0)
      |=> loop_count == 32'hffffffff)
      else $error("loop count did not wrap to all ones");

   AST_READ_HALF: assert property (@(posedge clk) // RULE20
      disable iff (!rst_n) (spr_rd_en && rsel == USP_SEL_TIME_LO_RD)
      |=> spr_rdata == $past(tbus.lower))
      else $error("lower time half not returned");

   AST_COUNT_DEC: assert property (@(posedge clk) disable iff (!rst_n)
      (br_valid && br_dec_count)
      |=> loop_count == $past(loop_count) - 32'h1) // RULE13
      else $error("loop count not decremented");

   AST_TIME_USER_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
      (spr_wr_en && !spr_supervisor && !time_tick)
      |=> ($stable(tbus.upper) && $stable(tbus.lower))) // RULE18
      else $error("user write changed the time count");

   AST_LINK_MASK: assert property (@(posedge clk) disable iff (!rst_n)
      link_target[1:0] == 2'b00) // RULE11
      else $error("link target low bits not masked");

endmodule
`default_nettype wire

//--- test/usp_units_model.sv
`timescale 1ns/1ns
`default_nettype none
// behavioural stand-in for the integer and branch execution units
module usp_units_model (
   input  wire logic        clk,            // core clock
   output logic             arith_valid,    // add/subtract completes
   output logic             arith_ovf_en,   // overflow-record enable
   output logic             arith_carrying, // carrying form
   output logic [31:0]      arith_a,        // first addend
   output logic [31:0]      arith_b,        // second addend
   output logic             arith_cin,      // third addend
   output logic             sra_valid,      // shift completes
   output logic [31:0]      sra_src,        // shifted operand
   output logic [5:0]       sra_amt,        // shift amount
   output logic             br_valid,       // branch completes
   output logic             br_link,        // link requested
   output logic             br_dec_count,   // decrement requested
   output logic [31:0]      br_next_addr    // following address
);
   // every unit idle from time zero
   initial begin
      {arith_valid, arith_ovf_en, arith_carrying, arith_cin} = 4'h0;
      {arith_a, arith_b, sra_src, br_next_addr} = '0;
      {sra_valid, br_valid, br_link, br_dec_count} = 4'h0;
      sra_amt = 6'h00;
   end
   ////////////////////////////////////////////////////////////////////
   // one add/subtract completion, operands as the adder sees them
   task automatic add_op(input logic ovf, input logic cy,
                         input logic [31:0] a, input logic [31:0] b,
                         input logic ci);
      @(negedge clk);
      {arith_valid, arith_ovf_en, arith_carrying} = {1'b1, ovf, cy};
      {arith_a, arith_b, arith_cin} = {a, b, ci}; // full sum
      @(negedge clk);
      arith_valid = 1'b0;
      // stale operands are not left looking valid
      {arith_a, arith_b, arith_cin} = {~a, ~b, ~ci};
   endtask
   // one shift right algebraic completion
   task automatic sra_op(input logic [31:0] src, input logic [5:0] amt);
      @(negedge clk);
      {sra_valid, sra_src, sra_amt} = {1'b1, src, amt};
      @(negedge clk);
      sra_valid = 1'b0;
      sra_src   = ~src;
   endtask
   // one branch completion with link and decrement options
   task automatic br_op(input logic lk, input logic dc,
                        input logic [31:0] nxt);
      @(negedge clk);
      {br_valid, br_link, br_dec_count, br_next_addr} = {1'b1, lk, dc, nxt};
      @(negedge clk);
      {br_valid, br_link, br_dec_count} = 3'h0;
      br_next_addr = ~nxt;
   endtask
endmodule
`default_nettype wire

//--- test/tb_usp_sprs.sv
`timescale 1ns/1ns
`default_nettype none
// self-checking bench for the user-level special-purpose registers
module tb_usp_sprs;
   import usp_pkg::*;
   logic        clk, rst_n, spr_wr_en, spr_rd_en, spr_supervisor, time_tick;
   logic [9:0]  spr_num;                    // register number
   logic [31:0] spr_wdata, spr_rdata;       // move data
   logic        arith_valid, arith_ovf_en, arith_carrying, arith_cin;
   logic [31:0] arith_a, arith_b, sra_src, br_next_addr;
   logic [5:0]  sra_amt;                    // shift amount
   logic        sra_valid, br_valid, br_link, br_dec_count;
   logic [31:0] link_target, count_target, loop_count_val;
   logic        summary_ovf, carry_flag;    // flag outputs
   logic [6:0]  string_bytes;               // string length
   int          fails, n_compared;          // tallies
   logic [31:0] rd;                         // last read value
   usp_sprs usp_sprs_i (.*);
   usp_units_model usp_units_model_i (.*);
   ////////////////////////////////////////////////////////////////////
   // clock at 50 MHz
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // compare one value and tally it
   task automatic check(input string nm, input logic [31:0] seen,
                        input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // move-to, one strobe cycle at the falling edge
   task automatic wr(input logic [9:0] n, input logic [31:0] d,
                     input logic sup);
      @(negedge clk);
      {spr_wr_en, spr_num, spr_wdata, spr_supervisor} = {1'b1, n, d, sup};
      @(negedge clk);
      {spr_wr_en, spr_supervisor} = 2'h0;
      spr_wdata = ~d;
   endtask
   // move-from, data taken one edge after the strobe
   task automatic rdr(input logic [9:0] n);
      @(negedge clk);
      {spr_rd_en, spr_num} = {1'b1, n};
      @(negedge clk);
      spr_rd_en = 1'b0;
      rd = spr_rdata;
   endtask
   // run-end verdict
   task automatic results;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////
   // field storage and reserved bits of the flags word
   task automatic t_fields;
      wr(10'h001, 32'hffff_ffff, 1'b0);
      rdr(10'h001);
      check("flags word", rd, 32'he000_ff7f);
      check("string bytes", {25'h0, string_bytes}, 32'h7f);
      wr(10'h001, 32'h0000_0a05, 1'b0);
      rdr(10'h001);
      check("flags low", rd, 32'h0000_0a05);
      $display("test fields done");
   endtask
   // overflow, sticky summary and carry from add/subtract
   task automatic t_arith;
      wr(10'h001, 32'h0, 1'b0);
      usp_units_model_i.add_op(1'b1, 1'b0, 32'h7fff_ffff, 32'h0, 1'b1);
      rdr(10'h001);
      check("ovf set", rd, 32'hc000_0000);
      usp_units_model_i.add_op(1'b1, 1'b0, 32'h1, 32'h1, 1'b0);
      rdr(10'h001);
      check("ovf clear", rd, 32'h8000_0000);
      usp_units_model_i.add_op(1'b0, 1'b0, 32'h7fff_ffff, 32'h0, 1'b1);
      rdr(10'h001);
      check("no ovf op", rd, 32'h8000_0000);
      wr(10'h001, 32'h0, 1'b0);
      usp_units_model_i.add_op(1'b0, 1'b1, 32'hffff_ffff, 32'h0, 1'b1);
      @(negedge clk);
      check("three sum carry", {31'h0, carry_flag}, 32'h1);
      usp_units_model_i.add_op(1'b1, 1'b1, 32'h8000_0000, 32'h8000_0000,
                               1'b0);
      rdr(10'h001);
      check("both flags", rd, 32'he000_0000);
      usp_units_model_i.add_op(1'b0, 1'b1, 32'h1, 32'h1, 1'b0);
      wr(10'h001, 32'h0, 1'b0);
      @(negedge clk);
      check("sticky cleared", {31'h0, summary_ovf}, 32'h0);
      $display("test arith done");
   endtask
   // carry from shift right algebraic
   task automatic t_shift;
      logic [31:0] src[4] = '{32'h8000_0001, 32'h8000_0000, 32'h1,
                              32'h8000_0000};
      logic [5:0]  amt[4] = '{6'h01, 6'h01, 6'h01, 6'h28};
      logic        cy[4]  = '{1'b1, 1'b0, 1'b0, 1'b1};
      for (int i = 0; i < 4; i++) begin
         usp_units_model_i.sra_op(src[i], amt[i]);
         @(negedge clk);
         check("shift carry", {31'h0, carry_flag}, {31'h0, cy[i]});
      end
      $display("test shift done");
   endtask
   // link and count registers with branches
   task automatic t_branch;
      wr(10'h008, 32'h1234_5677, 1'b0);
      rdr(10'h008);
      check("link low bits", rd, 32'h1234_5677);
      check("link target", link_target, 32'h1234_5674);
      usp_units_model_i.br_op(1'b1, 1'b0, 32'h0000_1004);
      rdr(10'h008);
      check("link on branch", rd, 32'h0000_1004);
      wr(10'h009, 32'h1, 1'b0);
      usp_units_model_i.br_op(1'b0, 1'b1, 32'h0);
      @(negedge clk);
      check("count dec", loop_count_val, 32'h0);
      usp_units_model_i.br_op(1'b0, 1'b1, 32'h0);
      rdr(10'h009);
      check("count wrap", rd, 32'hffff_ffff);
      check("count target", count_target, 32'hffff_fffc);
      $display("test branch done");
   endtask
   // time count halves, privilege and tick carry
   task automatic t_time;
      wr(10'h11c, 32'hffff_ffff, 1'b1);
      wr(10'h11d, 32'h0000_0005, 1'b1);
      wr(10'h11c, 32'h0000_1234, 1'b0);
      wr(10'h10c, 32'h0000_0000, 1'b1);
      rdr(10'h10c);
      check("lower loaded", rd, 32'hffff_ffff);
      @(negedge clk);
      time_tick = 1'b1;
      @(negedge clk);
      time_tick = 1'b0;
      rdr(10'h10c);
      check("lower after tick", rd, 32'h0);
      rdr(10'h10d);
      check("upper after tick", rd, 32'h6);
      rdr(10'h3ff);
      check("unmapped read", rd, 32'h0);
      $display("test time done");
   endtask
   // reset keeps link, clears the time count
   task automatic t_reset;
      wr(10'h008, 32'h5a5a_5a5b, 1'b0);
      @(negedge clk);
      rst_n = 1'b0;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      rdr(10'h008);
      check("link kept", rd, 32'h5a5a_5a5b);
      rdr(10'h10d);
      check("upper reset", rd, 32'h0);
      $display("test reset done");
   endtask
   ////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      fails = 0;
      n_compared = 0;
      {rst_n, spr_wr_en, spr_rd_en, spr_supervisor, time_tick} = 5'h0;
      {spr_num, spr_wdata} = '0;
      repeat (10) @(negedge clk);
      rst_n = 1'b1;
      t_fields();
      t_arith();
      t_shift();
      t_branch();
      t_time();
      t_reset();
      results();
   end
   // watchdog far beyond the hundred or so cycles needed
   initial begin
      #100000;
      fails++;
      results();
   end
endmodule
`default_nettype wire
